// >>> rtl/long_timer_pkg.sv
package long_timer_pkg;

  // ==========================================================
  // Widths
  localparam int COUNT_WIDTH = 24;
  localparam int AFTER_RUN_WIDTH = 16;
  localparam int FUNC_WIDTH = 3;

  // ==========================================================
  // Prescaler stages
  localparam int PRESCALE1_DIV = 16;
  localparam int PRESCALE2_DIV = 2048;
  localparam int PRESCALE1_WIDTH = 4;
  localparam int PRESCALE2_WIDTH = 11;

  // ==========================================================
  // Oscillator and system clock
  localparam int OSC_FREQ_HZ = 32768;
  localparam int MCLK_FREQ_HZ = 40000000;
  localparam int OSC_HALF_CYCLES = MCLK_FREQ_HZ / (2 * OSC_FREQ_HZ);

  // ==========================================================
  // Reset values and full count
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [23:0] COUNT_FULL = 24'hffffff;
  localparam logic [15:0] AFTER_RUN_RESET = 16'h0000;
  localparam logic [23:0] WAKE_RESET = 24'h000000;

  // ==========================================================
  // Function select codes
  typedef enum logic [2:0] {
    FUNC_NONE = 3'h0,
    FUNC_INT = 3'h1,
    FUNC_OFF = 3'h2,
    FUNC_OFF_WAKE = 3'h3,
    FUNC_WAKE = 3'h4,
    FUNC_OVF = 3'h5
  } func_type;

  // Timer phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_AFTER_RUN = 3'h1,
    PH_WAIT_OFF = 3'h2,
    PH_WAKE_RUN = 3'h3,
    PH_STOPPED = 3'h4
  } phase_type;

endpackage

// >>> rtl/tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Tick carrier between prescaler and timer core
interface tick_if;
  logic calibration;
  logic clear;
  logic tick;
  modport source (input calibration, input clear, output tick);
  modport sink (output calibration, output clear, input tick);
endinterface
`default_nettype wire

// >>> rtl/osc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Internal oscillator and two-stage prescaler
module osc_prescaler
  import long_timer_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  tick_if.source tk // Tick carrier
);

  typedef struct packed {
    logic [15:0] oscCnt;
    logic [PRESCALE1_WIDTH-1:0] stage1;
    logic [PRESCALE2_WIDTH-1:0] stage2;
    logic tick;
  } pre_type;

  pre_type cur;
  pre_type next_cur;
  logic oscEdge;
  logic stage1Wrap;

  // ==========================================================
  // Divider chain
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    oscEdge = (cur.oscCnt == 16'(2 * OSC_HALF_CYCLES - 1));
    stage1Wrap = oscEdge && (cur.stage1 == PRESCALE1_WIDTH'(PRESCALE1_DIV - 1));
    if (tk.clear) begin
      next_cur.oscCnt = '0;
      next_cur.stage1 = '0;
      next_cur.stage2 = '0;
    end else begin
      next_cur.oscCnt = oscEdge ? '0 : cur.oscCnt + 16'h0001;
      if (oscEdge) begin
        next_cur.stage1 = cur.stage1 + 1'b1;
      end
      if (stage1Wrap) begin
        if (tk.calibration) begin
          next_cur.tick = 1'b1;
        end else begin
          next_cur.stage2 = cur.stage2 + 1'b1;
          next_cur.tick = (cur.stage2 ==
            PRESCALE2_WIDTH'(PRESCALE2_DIV - 1));
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tk.tick = cur.tick;

endmodule
`default_nettype wire

// >>> rtl/count_compare.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Equality and overflow detector
module count_compare
  import long_timer_pkg::*;
#(
  parameter int WIDTH = COUNT_WIDTH
) (
  input wire logic [WIDTH-1:0] count, // Counter value
  input wire logic [WIDTH-1:0] target, // Compare value
  output logic equal, // Count equals target
  output logic full // All bits high
);
  // Combinational compare
  assign equal = (count == target);
  assign full = &count;
endmodule
`default_nettype wire

// >>> rtl/long_timer.sv
`timescale 1ns/1ps
`default_nettype none
module long_timer
  import long_timer_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic timer_run_enable, // Host run enable
  input wire logic calibrationMode, // Bypass prescaler stage two
  input wire logic [2:0] functionSelect, // Timer function 1..5
  input wire logic afterRunWrite, // Strobe for after-run value
  input wire logic [15:0] afterRunData, // After-run write data
  input wire logic wakeWrite, // Strobe for wake-up value
  input wire logic [23:0] wakeData, // Wake-up write data
  input wire logic lowPowerEntry, // Device entering low-power-off
  input wire logic otherWake, // Wake by CAN, LIN or IO (pin)
  output logic [23:0] count, // Counter value
  output logic [15:0] afterRunValue, // After-run readback
  output logic [23:0] wakeValue, // Wake-up readback
  output logic end_of_count, // Terminal event flag
  output logic counter_overflow, // Overflow flag
  output logic interrupt_out_n, // Interrupt, active low
  output logic lowPowerRequest, // Pulse: enter low_power_off_mode
  output logic wakeRequest, // Pulse: wake, go to init mode
  output logic low_power_off_mode // Timer sees device in low power
);

  typedef struct packed {
    logic [23:0] count;
    logic [15:0] afterRun;
    logic [23:0] wake;
    phase_type phase;
    logic endFlag;
    logic ovfFlag;
    logic intN;
    logic offReq;
    logic wakeReq;
    logic lowPower;
    logic enPrev;
    logic [2:0] wakeSync;
  } timer_type;

  timer_type cur;
  timer_type next_cur;
  tick_if tk ();
  logic afterEqual;
  logic wakeEqual;
  logic countFull;
  logic wakeSeen;
  logic enRise;
  logic enFall;
  logic lowPowerNow;
  logic [23:0] afterWide;

  // ==========================================================
  // Prescaler and compare instances
  osc_prescaler prescaler (
    .mclk(mclk),
    .rst_n(rst_n),
    .tk(tk.source)
  );

  assign afterWide = {8'h00, cur.afterRun};

  count_compare #(.WIDTH(COUNT_WIDTH)) afterCmp (
    .count(cur.count),
    .target(afterWide),
    .equal(afterEqual),
    .full()
  );

  count_compare #(.WIDTH(COUNT_WIDTH)) wakeCmp (
    .count(cur.count),
    .target(cur.wake),
    .equal(wakeEqual),
    .full(countFull)
  );

  // Prescaler steering
  assign tk.calibration = calibrationMode;
  assign tk.clear = (cur.phase == PH_IDLE) || (cur.phase == PH_STOPPED)
    || (cur.phase == PH_WAIT_OFF);

  // ==========================================================
  // Timer state update
  always_comb begin
    next_cur = cur;
    next_cur.offReq = 1'b0;
    next_cur.wakeReq = 1'b0;
    next_cur.enPrev = timer_run_enable;
    next_cur.wakeSync = {cur.wakeSync[1:0], otherWake};
    wakeSeen = cur.wakeSync[2] && cur.wakeSync[1];
    enRise = timer_run_enable && !cur.enPrev;
    enFall = !timer_run_enable && cur.enPrev;
    lowPowerNow = cur.lowPower || lowPowerEntry;
    next_cur.lowPower = lowPowerNow;
    // Compare values written by the host
    if (afterRunWrite) begin
      next_cur.afterRun = afterRunData;
    end
    if (wakeWrite) begin
      next_cur.wake = wakeData;
    end
    if (enFall) begin
      // Freeze for readback; flags clear
      next_cur.phase = PH_IDLE;
      next_cur.endFlag = 1'b0;
      next_cur.ovfFlag = 1'b0;
      next_cur.intN = 1'b1;
    end else begin
      case (cur.phase)
        PH_IDLE: begin
          if (enRise || (timer_run_enable && lowPowerEntry)) begin
            next_cur.count = COUNT_RESET;
            next_cur.endFlag = 1'b0;
            next_cur.ovfFlag = 1'b0;
            next_cur.intN = 1'b1;
            case (functionSelect)
              FUNC_INT, FUNC_OFF, FUNC_OFF_WAKE: begin
                if (!lowPowerNow) begin
                  next_cur.phase = PH_AFTER_RUN;
                end
              end
              FUNC_WAKE, FUNC_OVF: begin
                next_cur.phase = lowPowerNow ? PH_WAKE_RUN
                  : PH_WAIT_OFF;
              end
              default: begin
                next_cur.phase = PH_IDLE;
              end
            endcase
          end
        end
        PH_WAIT_OFF: begin
          if (lowPowerNow) begin
            next_cur.phase = PH_WAKE_RUN;
          end
        end
        PH_AFTER_RUN: begin
          if (tk.tick) begin
            next_cur.count = cur.count + 24'h000001;
          end
          if (afterEqual && cur.count != COUNT_RESET) begin
            next_cur.endFlag = 1'b1;
            case (functionSelect)
              FUNC_INT: begin
                next_cur.intN = 1'b0;
                next_cur.phase = PH_STOPPED;
              end
              FUNC_OFF: begin
                next_cur.offReq = 1'b1;
                next_cur.lowPower = 1'b1;
                next_cur.phase = PH_STOPPED;
              end
              FUNC_OFF_WAKE: begin
                next_cur.offReq = 1'b1;
                next_cur.lowPower = 1'b1;
                next_cur.count = COUNT_RESET; // Restart for wake-up phase
                next_cur.phase = PH_WAKE_RUN;
              end
              default: begin
                next_cur.phase = PH_STOPPED;
              end
            endcase
          end
        end
        PH_WAKE_RUN: begin
          if (tk.tick && !countFull) begin
            next_cur.count = cur.count + 24'h000001;
          end
          if (functionSelect == FUNC_OVF) begin
            if (countFull) begin
              next_cur.ovfFlag = 1'b1;
              next_cur.wakeReq = 1'b1;
              next_cur.lowPower = 1'b0;
              next_cur.phase = PH_STOPPED;
            end else if (wakeSeen) begin
              next_cur.lowPower = 1'b0;
            end
          end else if (wakeEqual && cur.count != COUNT_RESET) begin
            next_cur.endFlag = 1'b1;
            next_cur.wakeReq = 1'b1;
            next_cur.lowPower = 1'b0;
            next_cur.phase = PH_STOPPED;
          end else if (wakeSeen) begin
            next_cur.lowPower = 1'b0;
          end
        end
        PH_STOPPED: begin
          if (wakeSeen) begin
            next_cur.lowPower = 1'b0;
          end
        end
        default: begin
          next_cur.phase = PH_IDLE;
        end
      endcase
    end
    if (cur.phase != PH_WAKE_RUN && wakeSeen) begin
      next_cur.lowPower = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur.count <= COUNT_RESET;
      cur.afterRun <= AFTER_RUN_RESET;
      cur.wake <= WAKE_RESET;
      cur.phase <= PH_IDLE;
      cur.endFlag <= 1'b0;
      cur.ovfFlag <= 1'b0;
      cur.intN <= 1'b1;
      cur.offReq <= 1'b0;
      cur.wakeReq <= 1'b0;
      cur.lowPower <= 1'b0;
      cur.enPrev <= 1'b0;
      cur.wakeSync <= 3'h0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state
  assign count = cur.count;
  assign afterRunValue = cur.afterRun;
  assign wakeValue = cur.wake;
  assign end_of_count = cur.endFlag;
  assign counter_overflow = cur.ovfFlag;
  assign interrupt_out_n = cur.intN;
  assign lowPowerRequest = cur.offReq;
  assign wakeRequest = cur.wakeReq;
  assign low_power_off_mode = cur.lowPower;

endmodule
`default_nettype wire

// >>> verification/long_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module long_timer_monitor
  import long_timer_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic timer_run_enable, // Run
  input wire logic calibrationMode, // Short tick
  input wire logic [2:0] functionSelect, // Function
  input wire logic [23:0] count, // Counter
  input wire logic [15:0] afterRunValue, // After-run
  input wire logic [23:0] wakeValue, // Wake-up
  input wire logic end_of_count, // Match
  input wire logic interrupt_out_n, // Interrupt
  input wire logic lowPowerRequest, // To low power
  input wire logic wakeRequest // Wake
);
  localparam int TICK = 2 * OSC_HALF_CYCLES * PRESCALE1_DIV;
  logic [23:0] lastCount;
  logic [15:0] gap;
  logic prevInc;
  logic inc;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign inc = count == lastCount + 24'h1;
  // Cycles between counter steps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastCount <= '0;
      gap <= '0;
      prevInc <= 1'b0;
    end else begin
      lastCount <= count;
      if (count != lastCount) begin
        gap <= 16'h1;
        prevInc <= inc;
      end else if (gap != 16'hffff) begin
        gap <= gap + 16'h1;
      end
    end
  end
  property p_irq;
    $rose(end_of_count) && functionSelect == FUNC_INT |-> !interrupt_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_nolp;
    functionSelect == FUNC_INT |-> !lowPowerRequest;
  endproperty
  a_nolp: assert property (p_nolp) else $error("low power in fn1");
  property p_lp;
    lowPowerRequest |-> end_of_count && ((functionSelect == FUNC_OFF
      && count == {8'h0, afterRunValue})
      || (functionSelect == FUNC_OFF_WAKE && count == 24'h0));
  endproperty
  a_lp: assert property (p_lp) else $error("bad low power");
  property p_wake;
    wakeRequest && functionSelect != FUNC_OVF |-> count == wakeValue;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_pulse;
    lowPowerRequest || wakeRequest |=> !lowPowerRequest && !wakeRequest;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_idle;
    !(functionSelect inside {[3'h1:3'h5]}) |-> !end_of_count
      && !lowPowerRequest && !wakeRequest;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_step;
    $changed(count) |-> count == $past(count) + 24'h1 || count == '0;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_stop;
    end_of_count && timer_run_enable && functionSelect != FUNC_OFF_WAKE
      |=> $stable(count);
  endproperty
  a_stop: assert property (p_stop) else $error("not stopped");
  property p_tick;
    calibrationMode && inc && prevInc |-> gap == TICK;
  endproperty
  a_tick: assert property (p_tick) else $error("bad tick");
  c_irq: cover property ($fell(interrupt_out_n));
  c_lp: cover property (lowPowerRequest);
  c_wake: cover property (wakeRequest);
endmodule
bind long_timer long_timer_monitor mon_u (.mclk(mclk), .rst_n(rst_n),
  .timer_run_enable(timer_run_enable), .calibrationMode(calibrationMode),
  .functionSelect(functionSelect), .count(count),
  .afterRunValue(afterRunValue), .wakeValue(wakeValue),
  .end_of_count(end_of_count), .interrupt_out_n(interrupt_out_n),
  .lowPowerRequest(lowPowerRequest), .wakeRequest(wakeRequest));
`default_nettype wire

// >>> verification/power_manager_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Device power manager
module power_manager_model (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic lowPowerRequest, // Timer forces low power
  input wire logic goOff, // Host low-power command
  output logic lowPowerEntry // Entering low power
);
  // Enter low power a cycle after either cause
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowPowerEntry <= 1'b0;
    end else begin
      lowPowerEntry <= lowPowerRequest || goOff;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import long_timer_pkg::*;
  // ==========
  // Signals
  logic mclk, rst_n, runEn, calib, aWr, wWr, goOff, otherWake, lpEntry;
  logic eoc, ovf, irqN, lpReq, wkReq, lpMode, eocSeen;
  logic [2:0] fnSel;
  logic [15:0] aData, aVal;
  logic [23:0] wData, wVal, count, measured, scaled;
  logic [31:0] seed;
  logic [31:0] expQ[$];
  int err_count, checks_done;
  long_timer dut_u (.mclk(mclk), .rst_n(rst_n), .timer_run_enable(runEn),
    .calibrationMode(calib), .functionSelect(fnSel), .afterRunWrite(aWr),
    .afterRunData(aData), .wakeWrite(wWr), .wakeData(wData),
    .lowPowerEntry(lpEntry), .otherWake(otherWake), .count(count),
    .afterRunValue(aVal), .wakeValue(wVal), .end_of_count(eoc),
    .counter_overflow(ovf), .interrupt_out_n(irqN), .lowPowerRequest(lpReq),
    .wakeRequest(wkReq), .low_power_off_mode(lpMode));
  power_manager_model pm_u (.mclk(mclk), .rst_n(rst_n),
    .lowPowerRequest(lpReq), .goOff(goOff), .lowPowerEntry(lpEntry));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic checkEvt(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic checkVal(input logic [71:0] e, input logic [71:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic take(input logic [7:0] code);
    if (expQ.size() == 0) checkEvt(32'h0, {code, count});
    else checkEvt(expQ.pop_front(), {code, count});
  endtask
  // Event watcher
  always @(posedge mclk) begin
    eocSeen <= eoc;
    if (rst_n && eoc && !eocSeen) take(8'h01);
    if (rst_n && lpReq) take(8'h02);
    if (rst_n && wkReq) take(8'h03);
  end
  task automatic load(input logic [2:0] f, input logic [15:0] a,
      input logic [23:0] w);
    @(posedge mclk);
    fnSel <= f;
    aData <= a;
    wData <= w;
    aWr <= 1'b1;
    wWr <= 1'b1;
    @(posedge mclk);
    aWr <= 1'b0;
    wWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic runTimer(input logic [2:0] f, input logic [15:0] a,
      input logic [23:0] w);
    load(f, a, w);
    runEn <= 1'b1;
  endtask
  task automatic stop;
    @(posedge mclk);
    runEn <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic pulseOff;
    repeat (5) @(posedge mclk);
    goOff <= 1'b1;
    @(posedge mclk);
    goOff <= 1'b0;
  endtask
  task automatic waitQ;
    for (int i = 0; i < 45000 && expQ.size() > 0; i++) @(posedge mclk);
    if (expQ.size() > 0) begin
      expQ.delete();
      checkEvt(32'hffffffff, 32'h0);
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (110000) @(posedge mclk);
    err_count++;
    test_done;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    runEn = 1'b0;
    calib = 1'b1;
    aWr = 1'b0;
    wWr = 1'b0;
    goOff = 1'b0;
    otherWake = 1'b0;
    fnSel = FUNC_NONE;
    aData = '0;
    wData = '0;
    seed = 32'h243c;
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 checkVal({count, aVal, wVal, eoc, ovf, irqN, lpReq, wkReq, lpMode},
      {64'h0, 6'b001000});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      load(FUNC_NONE, seed[15:0], seed[31:8]);
      #1 checkVal({seed[15:0], seed[31:8]}, {aVal, wVal});
    end
    runTimer(3'h7, 16'h1, 24'h1);
    repeat (40) @(posedge mclk);
    stop;
    expQ.push_back({8'h01, 24'h2});
    runTimer(FUNC_INT, 16'h2, 24'h0);
    waitQ;
    #1 checkVal(1'b0, irqN);
    stop;
    #1 checkVal({1'b1, 24'h2}, {irqN, count});
    measured = count;
    scaled = 24'(32'h1 * measured / 32'h2);
    expQ.push_back({8'h01, 24'h0});
    expQ.push_back({8'h02, 24'h0});
    expQ.push_back({8'h03, 24'h1});
    runTimer(FUNC_OFF_WAKE, 16'h1, 24'h1);
    waitQ;
    stop;
    expQ.push_back({8'h01, 24'h1});
    expQ.push_back({8'h03, 24'h1});
    runTimer(FUNC_WAKE, 16'h0, scaled);
    pulseOff;
    waitQ;
    stop;
    runTimer(FUNC_OVF, 16'h0, 24'h0);
    pulseOff;
    otherWake <= 1'b1;
    repeat (20) @(posedge mclk);
    otherWake <= 1'b0;
    repeat (20) @(posedge mclk);
    #1 checkVal({1'b0, 1'b0, 1'b0}, {lpMode, ovf, wkReq});
    stop;
    test_done;
  end
endmodule
`default_nettype wire
